// >>> rtl/pfm_pin_cell.sv
// Purpose: combinational ownership and pad control for one shared pin
// Assumes: rank 0 is the port function and always present
// Notes: outputs are registered by the instantiating module

`timescale 1ns/1ps

module pfm_pin_cell
    import pfm_pkg::*;
(
    // claims and configuration
    input wire pfm_req_s [NRANK-1:0] req,
    input wire logic [NRANK-1:0] rank_mask,
    input wire logic slew_bit,
    input wire logic drive_bit,
    input wire logic pull_bit,
    // synchronised pad level
    input wire logic pad_in_s,
    // results
    output logic [2:0] owner,
    output logic pad_oe,
    output logic pad_out,
    output logic slew_on,
    output logic drive_hi,
    output logic pull_on,
    output logic [NRANK-1:0] din,
    output logic [NRANK-1:0] access
);

    // ==========================================================
    // priority pick
    // highest enabled rank wins
    function automatic logic [2:0] pick_owner(input logic [NRANK-1:0] en);
        logic [2:0] w;
        w = RANK_PORT;
        for (int r = 0; r < NRANK; r++) begin
            if (en[r]) begin
                w = 3'(r);
            end
        end
        return w;
    endfunction

    logic [NRANK-1:0] en;
    logic own_analog;
    logic any_analog;

    // effective enables; the port function is always a candidate
    always_comb begin
        for (int r = 0; r < NRANK; r++) begin
            en[r] = req[r].en & rank_mask[r];
        end
        en[0] = rank_mask[0];
    end

    // ==========================================================
    // pad control
    always_comb begin
        owner = pick_owner(en);
        own_analog = req[owner].analog;
        any_analog = 1'b0;
        for (int r = 0; r < NRANK; r++) begin
            any_analog = any_analog | (en[r] & req[r].analog);
        end
        // analog owners never drive the digital pad
        pad_oe = req[owner].oe & ~own_analog;
        pad_out = req[owner].dout & pad_oe;
        slew_on = slew_bit & pad_oe;
        drive_hi = drive_bit & pad_oe;
        // pullup never depends on port data or direction registers directly
        pull_on = pull_bit & ~pad_oe & ~any_analog;
    end

    // ==========================================================
    // what each function sees
    // every enabled digital function samples the pad, so a lower-ranked one can see
    // edges made by the owner; gating this would hide real pin activity
    always_comb begin
        for (int r = 0; r < NRANK; r++) begin
            din[r] = en[r] & ~req[r].analog & pad_in_s;
            // analog users share the pin with each other rather than exclude
            access[r] = en[r] & ((owner == 3'(r)) | (req[r].analog & own_analog));
        end
    end

endmodule // pfm_pin_cell

// >>> rtl/pfm_pin_mux.sv
// Purpose: per-pin drive, slew, pullup and function-sharing control for the port pins
// Assumes: peripherals and port logic run on clk; pad inputs are asynchronous
// Notes: every output is registered; pad input to function data takes three edges

`timescale 1ns/1ps

// Functional notes
// - per-pin slew limit bit limits driven outputs
// - slew bit ignored while pin is input
// - per-pin drive bit selects strong drive
// - highest enabled rank owns the pin
// - port a line4 ranks port, comparator, debug, mode
// - port b lines 7,6: port, two-wire, oscillator
// - b5 port, timer, select; b4 port, miso
// - b3..b0 port, keypad, serial, analog highest
// - a3,a2 port, keypad, two-wire, analog
// - select bit moves two-wire pins, resets to a3/a2
// - comparator and converter both reach shared pin
// - lower functions may see edges from owner
// - pin controls independent of port data registers
// - pullup off when driven or analog owned
module pfm_pin_mux
    import pfm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // per-pin configuration bits
    input wire logic [NPIN-1:0] slew_limit_enable_bits,
    input wire logic [NPIN-1:0] high_drive_select_bits,
    input wire logic [NPIN-1:0] pullup_enable_bits,
    // two-wire pin select from the second system options register
    input wire logic two_wire_pin_select,
    // function claims, per pin and rank; rank 2 on the two-wire pins is taken from tw_req
    input wire pfm_req_s [NPIN-1:0][NRANK-1:0] fn_req,
    input wire pfm_req_s [1:0] tw_req,
    // pads
    input wire logic [NPIN-1:0] pad_in,
    output logic [NPIN-1:0] pad_out_q,
    output logic [NPIN-1:0] pad_oe_q,
    output logic [NPIN-1:0] slew_on_q,
    output logic [NPIN-1:0] drive_hi_q,
    output logic [NPIN-1:0] pullup_on_q,
    // ownership and per-function views
    output logic [NPIN-1:0][2:0] owner_q,
    output logic [NPIN-1:0][NRANK-1:0] fn_din_q,
    output logic [NPIN-1:0][NRANK-1:0] fn_access_q,
    output logic [1:0] tw_din_q,
    output logic tw_sel_q
);

    // ==========================================================
    // pad input synchroniser
    logic [NPIN-1:0] pad_meta_q;
    logic [NPIN-1:0] pad_sync_q;

    // two stages; only the second is read by the mux
    always_ff @(posedge clk) begin
        if (rst) begin
            pad_meta_q <= '0;
            pad_sync_q <= '0;
        end else begin
            pad_meta_q <= pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // ==========================================================
    // two-wire placement
    // held in a flop so the pins sit on a3/a2 from reset until software moves them
    always_ff @(posedge clk) begin
        if (rst) begin
            tw_sel_q <= TW_SEL_RST;
        end else begin
            tw_sel_q <= two_wire_pin_select;
        end
    end

    // ==========================================================
    // effective claim table
    pfm_req_s [NPIN-1:0][NRANK-1:0] fn_req_eff;

    // the unselected pin pair loses its two-wire rank entirely, so no stale claim stays
    always_comb begin
        fn_req_eff = fn_req;
        fn_req_eff[PIN_PORT_A_LINE3][RANK_ALT2] = tw_sel_q ? '0 : tw_req[TW_CLK];
        fn_req_eff[PIN_PORT_A_LINE2][RANK_ALT2] = tw_sel_q ? '0 : tw_req[TW_DATA];
        fn_req_eff[PIN_PORT_B_LINE7][RANK_ALT2] = tw_sel_q ? tw_req[TW_CLK] : '0;
        fn_req_eff[PIN_PORT_B_LINE6][RANK_ALT2] = tw_sel_q ? tw_req[TW_DATA] : '0;
    end

    // ==========================================================
    // per-pin cells
    logic [NPIN-1:0][2:0] owner_c;
    logic [NPIN-1:0] pad_oe_c;
    logic [NPIN-1:0] pad_out_c;
    logic [NPIN-1:0] slew_c;
    logic [NPIN-1:0] drive_c;
    logic [NPIN-1:0] pull_c;
    logic [NPIN-1:0][NRANK-1:0] din_c;
    logic [NPIN-1:0][NRANK-1:0] access_c;

    // rank layout per pin comes from the mask table
    generate
        for (genvar p = 0; p < NPIN; p++) begin : g_pin
            pfm_pin_cell u_cell (
                .req(fn_req_eff[p]),
                .rank_mask(PIN_RANK_MASK[p]),
                .slew_bit(slew_limit_enable_bits[p]),
                .drive_bit(high_drive_select_bits[p]),
                .pull_bit(pullup_enable_bits[p]),
                .pad_in_s(pad_sync_q[p]),
                .owner(owner_c[p]),
                .pad_oe(pad_oe_c[p]),
                .pad_out(pad_out_c[p]),
                .slew_on(slew_c[p]),
                .drive_hi(drive_c[p]),
                .pull_on(pull_c[p]),
                .din(din_c[p]),
                .access(access_c[p])
            );
        end
    endgenerate

    // ==========================================================
    // output registers
    // pad electrical controls
    always_ff @(posedge clk) begin
        if (rst) begin
            pad_out_q <= '0;
            pad_oe_q <= '0;
            slew_on_q <= '0;
            drive_hi_q <= '0;
            pullup_on_q <= '0;
        end else begin
            pad_out_q <= pad_out_c;
            pad_oe_q <= pad_oe_c;
            slew_on_q <= slew_c;
            drive_hi_q <= drive_c;
            pullup_on_q <= pull_c;
        end
    end

    // ownership and function views
    always_ff @(posedge clk) begin
        if (rst) begin
            owner_q <= {NPIN{OWNER_RST}};
            fn_din_q <= '0;
            fn_access_q <= '0;
        end else begin
            owner_q <= owner_c;
            fn_din_q <= din_c;
            fn_access_q <= access_c;
        end
    end

    // two-wire receive data follows the selected pair
    always_ff @(posedge clk) begin
        if (rst) begin
            tw_din_q <= '0;
        end else if (tw_sel_q) begin
            tw_din_q[TW_CLK] <= din_c[PIN_PORT_B_LINE7][RANK_ALT2];
            tw_din_q[TW_DATA] <= din_c[PIN_PORT_B_LINE6][RANK_ALT2];
        end else begin
            tw_din_q[TW_CLK] <= din_c[PIN_PORT_A_LINE3][RANK_ALT2];
            tw_din_q[TW_DATA] <= din_c[PIN_PORT_A_LINE2][RANK_ALT2];
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_reset_release;
        rst ##1 !rst;
    endsequence

    sequence s_b3_shared;
        fn_req_eff[PIN_PORT_B_LINE3][RANK_ALT1].en && fn_req_eff[PIN_PORT_B_LINE3][RANK_ALT3].en;
    endsequence

    sequence s_a0_both_analog;
        fn_req_eff[PIN_PORT_A_LINE0][RANK_ALT3].en && fn_req_eff[PIN_PORT_A_LINE0][RANK_ALT3].analog
        && fn_req_eff[PIN_PORT_A_LINE0][RANK_ALT4].en
        && fn_req_eff[PIN_PORT_A_LINE0][RANK_ALT4].analog;
    endsequence

    a_slew_follow: assert property (
        ##1 slew_on_q == ($past(slew_limit_enable_bits) & pad_oe_q))
        else $error("slew control does not follow its bit");

    a_slew_input: assert property ((slew_on_q & ~pad_oe_q) == '0)
        else $error("slew control active on an input pin");

    a_drive_follow: assert property (
        ##1 drive_hi_q == ($past(high_drive_select_bits) & pad_oe_q))
        else $error("drive select does not follow its bit");

    a_pullup_off: assert property ((pullup_on_q & pad_oe_q) == '0)
        else $error("pullup on while pin driven");

    a_pullup_free: assert property (
        ##1 pullup_on_q == ($past(pullup_enable_bits & ~pad_oe_c & pull_c)
        | ($past(pullup_enable_bits) & $past(pull_c))))
        else $error("pullup not set by its own bit");

    a_rank_a4_top: assert property (
        fn_req_eff[PIN_PORT_A_LINE4][RANK_ALT4].en |=> owner_q[PIN_PORT_A_LINE4] == RANK_ALT4)
        else $error("mode select does not own port a line4");

    a_rank_a4_mid: assert property (
        fn_req_eff[PIN_PORT_A_LINE4][RANK_ALT2].en
        && !fn_req_eff[PIN_PORT_A_LINE4][RANK_ALT3].en
        && !fn_req_eff[PIN_PORT_A_LINE4][RANK_ALT4].en
        |=> owner_q[PIN_PORT_A_LINE4] == RANK_ALT2)
        else $error("comparator output lost port a line4");

    a_rank_b7_osc: assert property (
        fn_req_eff[PIN_PORT_B_LINE7][RANK_ALT3].en |=> owner_q[PIN_PORT_B_LINE7] == RANK_ALT3)
        else $error("oscillator does not own port b line7");

    a_rank_b5_b4: assert property (
        fn_req_eff[PIN_PORT_B_LINE4][RANK_ALT3].en
        && !fn_req_eff[PIN_PORT_B_LINE4][RANK_ALT2].en
        |=> owner_q[PIN_PORT_B_LINE4] == RANK_PORT
        && (owner_q[PIN_PORT_B_LINE5] != RANK_ALT1))
        else $error("missing rank claimed a pin");

    a_rank_b0_top: assert property (
        fn_req_eff[PIN_PORT_B_LINE0][RANK_ALT3].en |=> owner_q[PIN_PORT_B_LINE0] == RANK_ALT3)
        else $error("analog channel does not own port b line0");

    a_rank_a3_tw: assert property (
        !tw_sel_q && tw_req[TW_CLK].en
        && !fn_req_eff[PIN_PORT_A_LINE3][RANK_ALT3].en
        |=> owner_q[PIN_PORT_A_LINE3] == RANK_ALT2)
        else $error("two-wire clock does not own port a line3");

    a_tw_reset: assert property (disable iff (1'b0) s_reset_release |-> !tw_sel_q)
        else $error("two-wire pins not on default pair after reset");

    a_tw_moved: assert property (
        tw_sel_q && tw_req[TW_CLK].en |=> owner_q[PIN_PORT_A_LINE3] != RANK_ALT2)
        else $error("two-wire clock left on old pin");

    a_analog_both: assert property (
        s_a0_both_analog |=> fn_access_q[PIN_PORT_A_LINE0][RANK_ALT3]
        && fn_access_q[PIN_PORT_A_LINE0][RANK_ALT4])
        else $error("shared analog pin excluded a user");

    a_lower_sees: assert property (
        (s_b3_shared and !fn_req_eff[PIN_PORT_B_LINE3][RANK_ALT1].analog)
        |=> fn_din_q[PIN_PORT_B_LINE3][RANK_ALT1] == $past(pad_sync_q[PIN_PORT_B_LINE3]))
        else $error("lower function cut off from pad");

endmodule // pfm_pin_mux

// >>> rtl/pfm_pkg.sv
// Purpose: shared constants and carrier types for the pin function priority mux
// Assumes: thirteen shared port pins, five function ranks per pin (port plus four alternates)
// Notes: pin index 0..7 is port B line 0..7, pin index 8..12 is port A line 0..4

package pfm_pkg;

    // ==========================================================
    // sizes
    localparam int NPIN = 13;
    localparam int NRANK = 5;

    // ==========================================================
    // pin indices
    localparam int PIN_PORT_B_LINE0 = 0;
    localparam int PIN_PORT_B_LINE3 = 3;
    localparam int PIN_PORT_B_LINE4 = 4;
    localparam int PIN_PORT_B_LINE5 = 5;
    localparam int PIN_PORT_B_LINE6 = 6;
    localparam int PIN_PORT_B_LINE7 = 7;
    localparam int PIN_PORT_A_LINE0 = 8;
    localparam int PIN_PORT_A_LINE1 = 9;
    localparam int PIN_PORT_A_LINE2 = 10;
    localparam int PIN_PORT_A_LINE3 = 11;
    localparam int PIN_PORT_A_LINE4 = 12;

    // ==========================================================
    // rank codes, lowest to highest
    localparam logic [2:0] RANK_PORT = 3'h0;
    localparam logic [2:0] RANK_ALT1 = 3'h1;
    localparam logic [2:0] RANK_ALT2 = 3'h2;
    localparam logic [2:0] RANK_ALT3 = 3'h3;
    localparam logic [2:0] RANK_ALT4 = 3'h4;

    // two-wire bus signal slots
    localparam int TW_CLK = 0;
    localparam int TW_DATA = 1;

    // ==========================================================
    // which ranks exist on each pin, bit r = rank r; listed from pin 12 down to pin 0
    localparam logic [NPIN-1:0][NRANK-1:0] PIN_RANK_MASK = {
        5'h1d,  // port a line4: port, comparator out, debug serial, mode select
        5'h0f,  // port a line3: port, keypad, two-wire clock, analog
        5'h0f,  // port a line2: port, keypad, two-wire data, analog
        5'h1b,  // port a line1: port, keypad, analog, comparator minus
        5'h1f,  // port a line0: port, keypad, timer ch0, analog, comparator plus
        5'h0d,  // port b line7: port, two-wire clock, oscillator input
        5'h0d,  // port b line6: port, two-wire data, oscillator output
        5'h0d,  // port b line5: port, timer channel1, spi select
        5'h05,  // port b line4: port, miso
        5'h0f,  // port b line3: port, keypad 7, mosi, analog 7
        5'h0f,  // port b line2: port, keypad 6, serial peripheral clock, analog 6
        5'h0f,  // port b line1: port, keypad 5, transmit data, analog 5
        5'h0f   // port b line0: port, keypad 4, receive data, analog 4
    };

    // ==========================================================
    // reset values
    localparam logic TW_SEL_RST = 1'b0;
    localparam logic [2:0] OWNER_RST = 3'h0;

    // ==========================================================
    // one function's claim on a pin
    typedef struct packed {
        logic en;      // function enabled on this pin
        logic oe;      // function wants to drive the pin
        logic dout;    // level it drives
        logic analog;  // analog use of the pin
    } pfm_req_s;

endpackage

// >>> tb/pfm_pad_model.sv
// Purpose: board-side model of the shared pads seen by the pin function mux
// Assumes: pad levels are resolved from the mux drive, a board driver and the pullup
// Notes: an undriven, unpulled pad toggles every cycle instead of holding a stale level

`timescale 1ns/1ps

module pfm_pad_model
    import pfm_pkg::*;
(
    // clock
    input wire logic clk,
    // pad control from the mux
    input wire logic [NPIN-1:0] pad_oe_q,
    input wire logic [NPIN-1:0] pad_out_q,
    input wire logic [NPIN-1:0] pullup_on_q,
    // board-side driver
    input wire logic [NPIN-1:0] ext_en,
    input wire logic [NPIN-1:0] ext_level,
    // resolved pad level
    output logic [NPIN-1:0] pad_in
);
    // ==========================================================
    // floating level
    logic [NPIN-1:0] float_q = 13'h0aaa;

    // a floating pad wanders so that a read of it never matches by luck
    always @(posedge clk) begin
        float_q <= ~float_q;
    end

    // ==========================================================
    // pad resolution: mux drive wins, then board driver, then pullup
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            if (pad_oe_q[p]) begin
                pad_in[p] = pad_out_q[p];
            end else if (ext_en[p]) begin
                pad_in[p] = ext_level[p];
            end else if (pullup_on_q[p]) begin
                pad_in[p] = 1'b1;
            end else begin
                pad_in[p] = float_q[p];
            end
        end
    end
endmodule // pfm_pad_model

// >>> tb/pfm_pin_mux_tb.sv
// Purpose: self-checking bench for the pin function priority mux
// Assumes: one-edge answer on pad and ownership outputs, three edges from pad to function
// Notes: claims are applied by non-blocking assignment at the rising edge

`timescale 1ns/1ps

module pfm_pin_mux_tb
    import pfm_pkg::*;
();
    // ==========================================================
    // signals
    logic clk;
    logic rst;
    logic [NPIN-1:0] slew_bits, drive_bits, pull_bits, ext_en, ext_level, pad_in;
    logic tw_sel;
    pfm_req_s [NPIN-1:0][NRANK-1:0] fn_req;
    pfm_req_s [1:0] tw_req;
    logic [NPIN-1:0] pad_out_q, pad_oe_q, slew_on_q, drive_hi_q, pullup_on_q;
    logic [NPIN-1:0][2:0] owner_q;
    logic [NPIN-1:0][NRANK-1:0] fn_din_q, fn_access_q;
    logic [1:0] tw_din_q;
    logic tw_sel_q;
    int mismatches = 0;
    int checked = 0;
    // highest rank per pin, pin 0 first
    int top_rank [NPIN] = '{3, 3, 3, 3, 2, 3, 3, 3, 4, 4, 3, 3, 4};

    pfm_pin_mux uut (.clk(clk), .rst(rst), .slew_limit_enable_bits(slew_bits),
        .high_drive_select_bits(drive_bits), .pullup_enable_bits(pull_bits),
        .two_wire_pin_select(tw_sel), .fn_req(fn_req), .tw_req(tw_req), .pad_in(pad_in),
        .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q), .slew_on_q(slew_on_q),
        .drive_hi_q(drive_hi_q), .pullup_on_q(pullup_on_q), .owner_q(owner_q),
        .fn_din_q(fn_din_q), .fn_access_q(fn_access_q), .tw_din_q(tw_din_q),
        .tw_sel_q(tw_sel_q));

    pfm_pad_model pads (.clk(clk), .pad_oe_q(pad_oe_q), .pad_out_q(pad_out_q),
        .pullup_on_q(pullup_on_q), .ext_en(ext_en), .ext_level(ext_level), .pad_in(pad_in));

    // ==========================================================
    // clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========================================================
    // helpers
    function automatic pfm_req_s mk(input logic en, input logic oe, input logic dv,
                                    input logic an);
        mk = '{en: en, oe: oe, dout: dv, analog: an};
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // let the edges land, then sample off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic claim(input int p, input int r, input pfm_req_s v);
        @(posedge clk);
        fn_req[p][r] <= v;
    endtask

    task automatic clear_all();
        @(posedge clk);
        fn_req <= '0;
        tw_req <= '0;
        ext_en <= '0;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // a hang counts as a failure
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report();
    end

    // ==========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        {slew_bits, drive_bits, pull_bits, ext_en, ext_level} = '0;
        tw_sel = 1'b0;
        fn_req = '0;
        tw_req = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        chk("reset owner", 16'h0, 16'(owner_q[PIN_PORT_A_LINE4]));
        chk("reset oe", 16'h0, 16'(pad_oe_q));
        chk("reset select", 16'h0, 16'(tw_sel_q));
        $display("test reset done");

        // climb the ladder on every pin; each newly enabled rank must take over
        for (int p = 0; p < NPIN; p++) begin
            clear_all();
            for (int r = 0; r < NRANK; r++) begin
                if (PIN_RANK_MASK[p][r] && !(r == 2 && p inside {6, 7, 10, 11})) begin
                    claim(p, r, mk(1'b1, 1'b1, r[0], 1'b0));
                    settle(2);
                    chk("owner step", 16'(r), 16'(owner_q[p]));
                    chk("pad out", 16'(r[0]), 16'(pad_out_q[p]));
                end
            end
            chk("top owner", 16'(top_rank[p]),
                16'(owner_q[p]));
        end
        $display("test priority done");

        // an absent rank on port a line4 must not take the pin
        clear_all();
        claim(PIN_PORT_A_LINE4, 1, mk(1'b1, 1'b1, 1'b1, 1'b0));
        claim(PIN_PORT_B_LINE4, 3, mk(1'b1, 1'b1, 1'b1, 1'b0));
        settle(2);
        chk("absent rank", 16'h0, 16'(owner_q[PIN_PORT_A_LINE4]));
        chk("absent rank b4", 16'h0, 16'(owner_q[PIN_PORT_B_LINE4]));
        $display("test refused done");

        // slew, drive and pullup per pin, with only port b driven
        clear_all();
        for (int p = 0; p < 8; p++) begin
            fn_req[p][0] <= mk(1'b1, 1'b1, 1'b0, 1'b0);
        end
        slew_bits <= 13'h1fff;
        drive_bits <= 13'h0aaa;
        pull_bits <= 13'h1fff;
        settle(2);
        chk("slew", 16'h00ff, 16'(slew_on_q));
        chk("drive", 16'h00aa, 16'(drive_hi_q));
        chk("pullup", 16'h1f00, 16'(pullup_on_q));
        claim(PIN_PORT_A_LINE1, 3, mk(1'b1, 1'b0, 1'b0, 1'b1));
        settle(2);
        chk("analog pullup", 16'h1d00, 16'(pullup_on_q));
        chk("analog oe", 16'h00ff, 16'(pad_oe_q));
        $display("test pad control done");

        // two-wire clock on the default pair, then moved to port b
        clear_all();
        tw_req[0] <= mk(1'b1, 1'b1, 1'b1, 1'b0);
        settle(2);
        chk("tw a3 owner", 16'h2, 16'(owner_q[PIN_PORT_A_LINE3]));
        chk("tw a3 out", 16'h1, 16'(pad_out_q[PIN_PORT_A_LINE3]));
        chk("tw b7 owner", 16'h0, 16'(owner_q[PIN_PORT_B_LINE7]));
        // move at an edge; board holds data low so the two received bits differ
        @(posedge clk);
        tw_sel <= 1'b1;
        tw_req[1] <= mk(1'b1, 1'b0, 1'b0, 1'b0);
        ext_en[PIN_PORT_B_LINE6] <= 1'b1;
        ext_level[PIN_PORT_B_LINE6] <= 1'b0;
        settle(4);
        chk("tw b7 owner", 16'h2, 16'(owner_q[PIN_PORT_B_LINE7]));
        chk("tw a3 freed", 16'h0, 16'(owner_q[PIN_PORT_A_LINE3]));
        chk("tw data in", 16'h1, 16'(tw_din_q));
        chk("tw select", 16'h1, 16'(tw_sel_q));
        $display("test two wire done");

        // comparator and converter share port a line1
        clear_all();
        claim(PIN_PORT_A_LINE1, 3, mk(1'b1, 1'b0, 1'b0, 1'b1));
        claim(PIN_PORT_A_LINE1, 4, mk(1'b1, 1'b0, 1'b0, 1'b1));
        claim(PIN_PORT_A_LINE0, 3, mk(1'b1, 1'b0, 1'b0, 1'b1));
        claim(PIN_PORT_A_LINE0, 4, mk(1'b1, 1'b0, 1'b0, 1'b1));
        settle(2);
        chk("shared access", 16'h18, 16'(fn_access_q[PIN_PORT_A_LINE1]));
        chk("shared access a0", 16'h18, 16'(fn_access_q[PIN_PORT_A_LINE0]));
        $display("test analog share done");

        // keypad below the serial owner still sees the owner's edges
        clear_all();
        claim(PIN_PORT_B_LINE3, 1, mk(1'b1, 1'b0, 1'b0, 1'b0));
        claim(PIN_PORT_B_LINE3, 2, mk(1'b1, 1'b1, 1'b0, 1'b0));
        settle(5);
        chk("keypad low", 16'h0, 16'(fn_din_q[PIN_PORT_B_LINE3][1]));
        claim(PIN_PORT_B_LINE3, 2, mk(1'b1, 1'b1, 1'b1, 1'b0));
        settle(5);
        chk("keypad edge", 16'h1, 16'(fn_din_q[PIN_PORT_B_LINE3][1]));
        $display("test spurious edge done");
        final_report();
    end
endmodule // pfm_pin_mux_tb
